// [common/dma_chan_pkg.sv]
package dma_chan_pkg;
    localparam int AXI_ADDR_W = 8;
    localparam logic [7:0] OFS_EVENT = 8'h00;
    localparam logic [7:0] OFS_INT = 8'h04;
    localparam logic [7:0] OFS_SSA = 8'h08;
    localparam logic [7:0] OFS_DSA = 8'h0c;
    localparam logic [7:0] OFS_SSIZ = 8'h10;
    localparam logic [7:0] OFS_DSIZ = 8'h14;
    localparam logic [7:0] OFS_SPTR = 8'h18;
    localparam logic [7:0] OFS_DPTR = 8'h1c;
    localparam logic [7:0] OFS_CTRL = 8'h20;
    localparam logic [7:0] OFS_CSIZ = 8'h24;
    localparam logic [7:0] OFS_PAT = 8'h28;
    // event control fields
    localparam int EV_AIRQ_LSB = 16;
    localparam int EV_SIRQ_LSB = 8;
    localparam int EV_FORCE = 7;
    localparam int EV_ABORT = 6;
    localparam int EV_PAT_ABORT_EN = 5;
    localparam int EV_START_EN = 4;
    localparam int EV_ABORT_EN = 3;
    // interrupt control fields and flag positions
    localparam int INT_IE_LSB = 16;
    localparam int FL_SDONE = 7;
    localparam int FL_SHALF = 6;
    localparam int FL_DDONE = 5;
    localparam int FL_DHALF = 4;
    localparam int FL_BLOCK = 3;
    localparam int FL_CELL = 2;
    localparam int FL_ABORT = 1;
    localparam int FL_AERR = 0;
    // own control register fields
    localparam int CTRL_BUSY = 15;
    localparam int CTRL_ON = 7;
    localparam int CTRL_AUTO = 4;
    localparam logic [7:0] SEL_RESET = 8'hff;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    localparam logic [16:0] SIZE_FULL = 17'h1_0000;
    localparam logic [16:0] ONE17 = 17'h0_0001;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_MOVE} chan_state_t;
    typedef struct packed {
        logic [31:0] src;
        logic [31:0] dst;
    } xfer_addr_t;
    typedef struct packed {
        logic valid;
        logic [7:0] num;
    } irq_event_t;
    typedef struct packed {
        logic ack;
        logic err;
        logic [7:0] data;
    } xfer_ack_t;
endpackage

// [hdl/dma_channel_event_and_status.sv]
`timescale 1ns/10ps
module dma_channel_event_and_status (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [dma_chan_pkg::AXI_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [dma_chan_pkg::AXI_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire dma_chan_pkg::irq_event_t irq_in,
    output logic xfer_req,
    output dma_chan_pkg::xfer_addr_t xfer_addr,
    input wire dma_chan_pkg::xfer_ack_t xfer_resp,
    output logic chan_irq,
    output logic busy
);
    import dma_chan_pkg::*;

    logic [7:0] abort_irq_select;
    logic [7:0] start_irq_select;
    logic pattern_abort_enable;
    logic start_irq_enable;
    logic abort_irq_enable;
    logic [7:0] int_enable;
    logic [7:0] flags;
    logic [31:0] source_start_addr;
    logic [31:0] dest_start_addr;
    logic [15:0] source_size;
    logic [15:0] dest_size;
    logic [15:0] cell_size;
    logic [7:0] pattern_value;
    logic channel_on;
    logic auto_reenable;
    logic [15:0] source_pointer;
    logic [15:0] dest_pointer;
    logic [16:0] cell_pointer;
    logic [16:0] block_count;
    chan_state_t state;
    logic aw_held;
    logic w_held;
    logic [AXI_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    // zero size stands for the full 64 KiB length
    function automatic logic [16:0] eff_size(input logic [15:0] s);
        eff_size = (s == 16'h0000) ? SIZE_FULL : {1'b0, s};
    endfunction

    function automatic logic map_hit(input logic [AXI_ADDR_W-1:0] a);
        logic [AXI_ADDR_W-1:0] w;
        w = {a[AXI_ADDR_W-1:2], 2'b00};
        map_hit = (w == OFS_EVENT) || (w == OFS_INT) || (w == OFS_SSA) || (w == OFS_DSA)
            || (w == OFS_SSIZ) || (w == OFS_DSIZ) || (w == OFS_SPTR) || (w == OFS_DPTR)
            || (w == OFS_CTRL) || (w == OFS_CSIZ) || (w == OFS_PAT);
    endfunction

    // register images; strobe bits read zero, unimplemented bits zero
    function automatic logic [31:0] reg_image(input logic [AXI_ADDR_W-1:0] a);
        logic [AXI_ADDR_W-1:0] w;
        w = {a[AXI_ADDR_W-1:2], 2'b00};
        reg_image = ZERO32;
        unique case (w)
            OFS_EVENT: begin
                reg_image[EV_AIRQ_LSB+:8] = abort_irq_select;
                reg_image[EV_SIRQ_LSB+:8] = start_irq_select;
                reg_image[EV_PAT_ABORT_EN] = pattern_abort_enable;
                reg_image[EV_START_EN] = start_irq_enable;
                reg_image[EV_ABORT_EN] = abort_irq_enable;
            end
            OFS_INT: begin
                reg_image[INT_IE_LSB+:8] = int_enable;
                reg_image[7:0] = flags;
            end
            OFS_SSA: reg_image = source_start_addr;
            OFS_DSA: reg_image = dest_start_addr;
            OFS_SSIZ: reg_image[15:0] = source_size;
            OFS_DSIZ: reg_image[15:0] = dest_size;
            OFS_SPTR: reg_image[15:0] = source_pointer;
            OFS_DPTR: reg_image[15:0] = dest_pointer;
            OFS_CTRL: begin
                reg_image[CTRL_BUSY] = (state != ST_IDLE);
                reg_image[CTRL_ON] = channel_on;
                reg_image[CTRL_AUTO] = auto_reenable;
            end
            OFS_CSIZ: reg_image[15:0] = cell_size;
            OFS_PAT: reg_image[7:0] = pattern_value;
            default: reg_image = ZERO32;
        endcase
    endfunction

    function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] d,
                                                input logic [3:0] s);
        apply_strb = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                apply_strb[i*8+:8] = d[i*8+:8];
            end
        end
    endfunction

    // bus handshakes; address and data may come in either order
    wire do_write = aw_held && w_held && !bvalid;
    wire wr_hit = map_hit(wr_addr);
    wire [AXI_ADDR_W-1:0] wr_word = {wr_addr[AXI_ADDR_W-1:2], 2'b00};
    wire [31:0] wr_new = apply_strb(reg_image(wr_addr), wr_data, wr_strb);
    wire wr_event = do_write && (wr_word == OFS_EVENT);
    wire wr_int = do_write && (wr_word == OFS_INT);
    wire wr_ctrl = do_write && (wr_word == OFS_CTRL);
    wire ar_take = arvalid && arready;
    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign arready = !rvalid;

    // write channel capture and response
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= '0;
            wr_data <= ZERO32;
            wr_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                wr_addr <= awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                wr_data <= wdata;
                wr_strb <= wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
            if (do_write) begin
                bvalid <= 1'b1;
                bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // read channel; unmapped reads return zero with an error
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rvalid <= 1'b0;
            rdata <= ZERO32;
            rresp <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid <= 1'b1;
            rdata <= reg_image(araddr);
            rresp <= map_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // transfer progress decode
    wire [16:0] src_eff = eff_size(source_size);
    wire [16:0] dst_eff = eff_size(dest_size);
    wire [16:0] cell_eff = eff_size(cell_size);
    wire [16:0] blk_max = (src_eff > dst_eff) ? src_eff : dst_eff;
    wire [16:0] next_src = {1'b0, source_pointer} + ONE17;
    wire [16:0] next_dst = {1'b0, dest_pointer} + ONE17;
    wire [16:0] next_cell = cell_pointer + ONE17;
    wire [16:0] next_blk = block_count + ONE17;
    wire moving = (state == ST_MOVE);
    wire move_ok = moving && xfer_resp.ack && !xfer_resp.err;
    wire move_err = moving && xfer_resp.ack && xfer_resp.err;
    wire src_done = move_ok && (next_src == src_eff);
    wire src_half = move_ok && (next_src == (src_eff >> 1));
    wire dst_done = move_ok && (next_dst == dst_eff);
    wire dst_half = move_ok && (next_dst == (dst_eff >> 1));
    wire blk_done = move_ok && (next_blk == blk_max);
    wire cell_done = move_ok && (next_cell == cell_eff);
    // byte compare only runs with pattern abort on
    wire pat_hit = move_ok && pattern_abort_enable && (xfer_resp.data == pattern_value);

    // event decode from interrupt numbers and strobe bits
    wire start_match = irq_in.valid && start_irq_enable
        && (irq_in.num == start_irq_select);
    wire abort_match = irq_in.valid && abort_irq_enable && channel_on
        && (irq_in.num == abort_irq_select);
    wire force_pulse = wr_event && wr_new[EV_FORCE];
    wire soft_pulse = wr_event && wr_new[EV_ABORT];
    wire any_abort = abort_match || soft_pulse || move_err || pat_hit;
    wire restart = any_abort || blk_done;
    wire start_go = (state == ST_IDLE) && channel_on && (force_pulse || start_match)
        && !abort_match && !soft_pulse;
    wire [7:0] flag_set = {src_done, src_half, dst_done, dst_half, blk_done || pat_hit,
        cell_done, abort_match, move_err};

    assign xfer_req = moving;
    assign busy = (state != ST_IDLE);
    assign chan_irq = |(flags & int_enable);

    // channel sequencer; addresses are loaded a cycle before each request
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state <= ST_IDLE;
        end else if (abort_match || soft_pulse) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: if (start_go) begin
                    state <= ST_LOAD;
                end
                ST_LOAD: state <= ST_MOVE;
                ST_MOVE: if (xfer_resp.ack) begin
                    state <= (any_abort || blk_done || cell_done) ? ST_IDLE : ST_LOAD;
                end
            endcase
        end
    end

    // pointers wrap at their sizes and restart on abort or block end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            source_pointer <= 16'h0000;
            dest_pointer <= 16'h0000;
            cell_pointer <= 17'h0_0000;
            block_count <= 17'h0_0000;
        end else if (restart) begin
            source_pointer <= 16'h0000;
            dest_pointer <= 16'h0000;
            cell_pointer <= 17'h0_0000;
            block_count <= 17'h0_0000;
        end else if (move_ok) begin
            source_pointer <= src_done ? 16'h0000 : next_src[15:0];
            dest_pointer <= dst_done ? 16'h0000 : next_dst[15:0];
            cell_pointer <= cell_done ? 17'h0_0000 : next_cell;
            block_count <= next_blk;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            xfer_addr <= '0;
        end else if (state == ST_LOAD) begin
            xfer_addr.src <= source_start_addr + {16'h0000, source_pointer};
            xfer_addr.dst <= dest_start_addr + {16'h0000, dest_pointer};
        end
    end

    // flags: hardware set wins over a software write of zero
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            flags <= 8'h00;
        end else if (wr_int) begin
            flags <= (flags & wr_new[7:0]) | flag_set;
        end else begin
            flags <= flags | flag_set;
        end
    end

    // enable: a software write in the same cycle wins over hardware clear
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            channel_on <= 1'b0;
            auto_reenable <= 1'b0;
        end else if (wr_ctrl) begin
            channel_on <= wr_new[CTRL_ON];
            auto_reenable <= wr_new[CTRL_AUTO];
        end else if (any_abort || (blk_done && !auto_reenable)) begin
            channel_on <= 1'b0;
        end
    end

    // software configuration registers
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            abort_irq_select <= SEL_RESET;
            start_irq_select <= SEL_RESET;
            pattern_abort_enable <= 1'b0;
            start_irq_enable <= 1'b0;
            abort_irq_enable <= 1'b0;
            int_enable <= 8'h00;
            source_start_addr <= ZERO32;
            dest_start_addr <= ZERO32;
            source_size <= 16'h0000;
            dest_size <= 16'h0000;
            cell_size <= 16'h0000;
            pattern_value <= 8'h00;
        end else if (do_write) begin
            if (wr_word == OFS_EVENT) begin
                abort_irq_select <= wr_new[EV_AIRQ_LSB+:8];
                start_irq_select <= wr_new[EV_SIRQ_LSB+:8];
                pattern_abort_enable <= wr_new[EV_PAT_ABORT_EN];
                start_irq_enable <= wr_new[EV_START_EN];
                abort_irq_enable <= wr_new[EV_ABORT_EN];
            end
            if (wr_word == OFS_INT) begin
                int_enable <= wr_new[INT_IE_LSB+:8];
            end
            if (wr_word == OFS_SSA) begin
                source_start_addr <= wr_new;
            end
            if (wr_word == OFS_DSA) begin
                dest_start_addr <= wr_new;
            end
            if (wr_word == OFS_SSIZ) begin
                source_size <= wr_new[15:0];
            end
            if (wr_word == OFS_DSIZ) begin
                dest_size <= wr_new[15:0];
            end
            if (wr_word == OFS_CSIZ) begin
                cell_size <= wr_new[15:0];
            end
            if (wr_word == OFS_PAT) begin
                pattern_value <= wr_new[7:0];
            end
        end
    end

    // checks
    chk_irq_abort_stop: assert property (@(posedge mclk) disable iff (reset)
        abort_match |=> (state == ST_IDLE) && flags[FL_ABORT])
        else $error("abort interrupt did not stop channel");
    chk_abort_disabled: assert property (@(posedge mclk) disable iff (reset)
        (moving && !abort_irq_enable && !xfer_resp.ack && !soft_pulse) |=> moving)
        else $error("disabled abort interrupt stopped channel");
    chk_start_irq_go: assert property (@(posedge mclk) disable iff (reset)
        (start_go && start_match) |=> (state == ST_LOAD)
        ##1 (xfer_req || $past(abort_match || soft_pulse)))
        else $error("start interrupt did not begin a cell");
    chk_start_disabled: assert property (@(posedge mclk) disable iff (reset)
        (state == ST_IDLE && !start_irq_enable && !force_pulse) |=> state == ST_IDLE)
        else $error("channel started without a start event");
    chk_strobe_read_zero: assert property (@(posedge mclk) disable iff (reset)
        (ar_take && araddr == OFS_EVENT) |=> !rdata[EV_FORCE] && !rdata[EV_ABORT])
        else $error("strobe bits read as one");
    chk_soft_abort: assert property (@(posedge mclk) disable iff (reset)
        soft_pulse |=> (state == ST_IDLE) && !channel_on)
        else $error("soft abort did not stop channel");
    chk_pattern_stop: assert property (@(posedge mclk) disable iff (reset)
        (pat_hit && !wr_ctrl) |=> !channel_on && flags[FL_BLOCK] && source_pointer == 16'h0000)
        else $error("pattern match did not end block");
    chk_src_done_wrap: assert property (@(posedge mclk) disable iff (reset)
        src_done |=> flags[FL_SDONE] && source_pointer == 16'h0000)
        else $error("source done not flagged");
    chk_dst_half: assert property (@(posedge mclk) disable iff (reset)
        dst_half |=> flags[FL_DHALF])
        else $error("destination half not flagged");
    chk_cell_end: assert property (@(posedge mclk) disable iff (reset)
        cell_done |=> (state == ST_IDLE) && flags[FL_CELL] && !xfer_req)
        else $error("cell end not honoured");
    chk_block_auto: assert property (@(posedge mclk) disable iff (reset)
        (blk_done && !auto_reenable && !wr_ctrl) |=> !channel_on)
        else $error("block end left channel enabled");
    chk_addr_err: assert property (@(posedge mclk) disable iff (reset)
        move_err |=> flags[FL_AERR] && !busy)
        else $error("address error not flagged");
    chk_size_upper: assert property (@(posedge mclk) disable iff (reset)
        (ar_take && (araddr == OFS_SSIZ || araddr == OFS_DSIZ)) |=> rdata[31:16] == 16'h0000)
        else $error("size upper half not zero");
    chk_reset_values: assert property (@(posedge mclk)
        $fell(reset) |-> abort_irq_select == SEL_RESET && start_irq_select == SEL_RESET
        && flags == 8'h00 && source_size == 16'h0000)
        else $error("wrong value after reset");
    chk_flag_irq: assert property (@(posedge mclk) disable iff (reset)
        (flag_set[FL_CELL] && int_enable[FL_CELL] && !wr_int) |=> chan_irq)
        else $error("enabled flag raised no interrupt");
    cov_cell_done: cover property (@(posedge mclk) disable iff (reset) cell_done);
    cov_block_done: cover property (@(posedge mclk) disable iff (reset) blk_done);
    cov_pattern: cover property (@(posedge mclk) disable iff (reset) pat_hit);
    cov_irq_abort: cover property (@(posedge mclk) disable iff (reset) abort_match && moving);
endmodule // dma_channel_event_and_status

// [dv/far_side_model.sv]
`timescale 1ns/10ps
module far_side_model (
    input wire logic mclk,
    input wire logic reset,
    input wire logic xfer_req,
    input wire dma_chan_pkg::xfer_addr_t xfer_addr,
    input wire logic [3:0] wait_cycles,
    output dma_chan_pkg::xfer_ack_t xfer_resp
);
    import dma_chan_pkg::*;
    logic [3:0] wait_cnt;
    // one byte per request after a stall; top 256 MB counts as a bad address
    // the returned byte is the source address low byte, so pattern hits are predictable
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wait_cnt <= 4'h0;
            xfer_resp <= '0;
        end else if (xfer_req && !xfer_resp.ack && wait_cnt >= wait_cycles) begin
            xfer_resp.ack <= 1'b1;
            xfer_resp.err <= (xfer_addr.src[31:28] == 4'hf) || (xfer_addr.dst[31:28] == 4'hf);
            xfer_resp.data <= xfer_addr.src[7:0];
            wait_cnt <= 4'h0;
        end else begin
            xfer_resp.ack <= 1'b0;
            xfer_resp.err <= ~xfer_resp.err; // no stale answer after release
            xfer_resp.data <= ~xfer_resp.data;
            wait_cnt <= xfer_req ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule // far_side_model

// [dv/dma_channel_event_and_status_tb.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); \
    end \
end
module dma_channel_event_and_status_tb;
    import dma_chan_pkg::*;
    logic mclk = 1'b0, reset = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, xfer_req, chan_irq, busy;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, sel, abt, f;
    logic [31:0] wdata = 32'h0000_0000, rdata, d, v;
    logic [3:0] wstrb = 4'hf, wait_cycles = 4'h0;
    logic [1:0] bresp, rresp, r;
    irq_event_t irq_in = '0;
    xfer_addr_t xfer_addr;
    xfer_ack_t xfer_resp;
    int failures = 0, total_checks = 0, seed = 44307, t, s, c, m;
    dma_channel_event_and_status dut (.mclk(mclk), .reset(reset), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .irq_in(irq_in), .xfer_req(xfer_req), .xfer_addr(xfer_addr),
        .xfer_resp(xfer_resp), .chan_irq(chan_irq), .busy(busy));
    far_side_model far (.mclk(mclk), .reset(reset), .xfer_req(xfer_req),
        .xfer_addr(xfer_addr), .wait_cycles(wait_cycles), .xfer_resp(xfer_resp));
    initial begin
        forever #20 mclk = ~mclk;
    end
    task automatic wrap_up();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic give_up();
        failures++;
        wrap_up();
    endtask
    // address and data go out together; bready stays up until the response
    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        int n;
        @(posedge mclk);
        awaddr <= a;
        wdata <= x;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 50) give_up();
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 50) give_up();
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // two edges first so a start launched just before is already visible
    task automatic wait_idle();
        int n;
        repeat (2) @(posedge mclk);
        for (n = 0; n < 400 && busy !== 1'b0; n++) @(posedge mclk);
        if (n == 400) give_up();
    endtask
    task automatic fire(input logic [7:0] num);
        @(posedge mclk);
        irq_in <= '{valid: 1'b1, num: num};
        @(posedge mclk);
        irq_in <= '0;
    endtask
    // flags raised by one cell of c bytes after m bytes, equal sizes s
    function automatic logic [7:0] exp_flags(int s, int c, int m);
        logic [7:0] e;
        e = 8'h04;
        for (int k = m + 1; k <= m + c; k++) begin
            if (k == s) e = e | 8'ha8;
            if (k == s / 2) e = e | 8'h50;
        end
        return e;
    endfunction
    initial begin
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        rd(OFS_EVENT);
        `CHK(d, 32'h00ff_ff00)
        for (t = 1; t < 6; t++) begin
            rd(8'(t * 4));
            `CHK(d, ZERO32)
        end
        wr(8'h40, 32'h1234_5678);
        `CHK(r, RESP_SLVERR)
        rd(8'h40);
        `CHK({r, d}, {RESP_SLVERR, ZERO32})
        v = $random(seed);
        wr(OFS_SSIZ, v);
        wr(OFS_DSIZ, ~v);
        rd(OFS_SSIZ);
        `CHK(d, {16'h0000, v[15:0]})
        rd(OFS_DSIZ);
        `CHK(d, {16'h0000, ~v[15:0]})
        wr(OFS_EVENT, 32'h0012_34f8);
        rd(OFS_EVENT);
        `CHK(d, 32'h0012_3438)
        wr(OFS_SSA, 32'h0000_0100); // physical address
        // random cells: force start, then start interrupt
        for (t = 0; t < 3; t++) begin
            s = 2 * (($random(seed) & 3) + 1);
            c = (t == 1) ? s / 2 : s;
            sel = $random(seed);
            wait_cycles <= 4'($random(seed));
            wr(OFS_SSIZ, 32'(s));
            wr(OFS_DSIZ, 32'(s));
            wr(OFS_CSIZ, 32'(c));
            wr(OFS_INT, 32'h00ff_0000);
            wr(OFS_CTRL, (t == 2) ? 32'h0000_0090 : 32'h0000_0080);
            wr(OFS_EVENT, {8'h00, 8'hff, sel, 8'h00});
            fire(sel);
            repeat (2) @(posedge mclk);
            `CHK(busy, 1'b0)
            wr(OFS_EVENT, {8'h00, 8'hff, sel, 8'h90});
            f = 8'h00;
            for (m = 0; m < s; m = m + c) begin
                if (m > 0) fire(sel);
                wait_idle();
                f = f | exp_flags(s, c, m);
                rd(OFS_INT);
                `CHK(d, {16'h00ff, 8'h00, f})
                `CHK(chan_irq, 1'b1)
                rd(OFS_SPTR);
                `CHK(d, 32'((m + c) % s))
                rd(OFS_DPTR);
                `CHK(d, 32'((m + c) % s))
            end
            rd(OFS_CTRL);
            `CHK(d, (t == 2) ? 32'h0000_0090 : ZERO32)
        end
        // abort interrupt ignored, then soft abort, then abort interrupt
        abt = sel + 8'h01;
        wait_cycles <= 4'hf;
        wr(OFS_SSIZ, 32'h0000_0008);
        wr(OFS_DSIZ, 32'h0000_0008);
        wr(OFS_CSIZ, 32'h0000_0008);
        wr(OFS_INT, 32'h0002_0000);
        wr(OFS_CTRL, 32'h0000_0080);
        wr(OFS_EVENT, {8'h00, abt, sel, 8'h80});
        fire(abt);
        repeat (2) @(posedge mclk);
        `CHK(busy, 1'b1)
        wr(OFS_EVENT, {8'h00, abt, sel, 8'h40});
        wait_idle();
        rd(OFS_INT);
        `CHK(d, 32'h0002_0000)
        wr(OFS_CTRL, 32'h0000_0080);
        wr(OFS_EVENT, {8'h00, abt, sel, 8'h88});
        fire(abt);
        wait_idle();
        rd(OFS_INT);
        `CHK(d, 32'h0002_0002)
        `CHK(chan_irq, 1'b1)
        wr(OFS_INT, 32'h0002_0000);
        `CHK(chan_irq, 1'b0)
        // pattern hit on the fourth byte
        wait_cycles <= 4'h0;
        wr(OFS_SSA, 32'h0000_0010);
        wr(OFS_PAT, 32'h0000_0013);
        wr(OFS_CTRL, 32'h0000_0080);
        wr(OFS_EVENT, {8'h00, abt, sel, 8'ha0});
        wait_idle();
        rd(OFS_INT);
        `CHK({d[7], d[3]}, 2'b01)
        rd(OFS_CTRL);
        `CHK(d, ZERO32)
        wr(OFS_SSA, 32'hf000_0000);
        wr(OFS_CTRL, 32'h0000_0080);
        wr(OFS_EVENT, {8'h00, abt, sel, 8'h80});
        wait_idle();
        rd(OFS_INT);
        `CHK(d[0], 1'b1)
        wrap_up();
    end
endmodule // dma_channel_event_and_status_tb
